// ===== hdl/status_cmd_defs.vh
// constants for the remote status and command handler
`ifndef STATUS_CMD_DEFS_VH
`define STATUS_CMD_DEFS_VH

// clock and timing, times in their own unit
`define CLK_HZ 100000000
`define CYC_PER_MS (`CLK_HZ / 1000)
`define T_RST_MS 200
`define T_RANGE_MS 150
`define T_FETCH_MS 3
`define T_ADJ_MS 2000
`define T_TST_MS 1000
`define T_BACKUP_MS 200
`define T_OTHER_MS 10
`define T_READ_EXTRA_MS 3
`define T_MEAS_MS 1
`define BAUD_BPS 9600
`define BAUD_DIV (`CLK_HZ / `BAUD_BPS)
`define FRAME_BITS 10

// limits and key reset values
`define RESP_MAX_BYTES 7'd64
`define GPIB_ADDR_RST 5'h01
`define RANGE_RST 8'h00

// register offsets
`define OFF_CMD 4'h0
`define OFF_RESP 4'h4
`define OFF_STAT 4'h8
`define OFF_CTRL 4'hC

// command word fields
`define CMD_OP_LSB 0
`define CMD_DATA_LSB 8
`define CMD_LEN_LSB 16
`define CMD_SYNERR_BIT 24
`define CMD_VALERR_BIT 25
`define CTRL_SERIAL_BIT 8
`define RESP_VALID_BIT 8
`define RESP_EOI_BIT 9
`define LF_CHAR 8'h0A

// opcodes
`define OP_CLS 5'h00
`define OP_ESE 5'h01
`define OP_ESE_Q 5'h02
`define OP_ESR_Q 5'h03
`define OP_OPC 5'h04
`define OP_OPC_Q 5'h05
`define OP_RST 5'h06
`define OP_SRE 5'h07
`define OP_SRE_Q 5'h08
`define OP_STB_Q 5'h09
`define OP_TRG 5'h0A
`define OP_TST_Q 5'h0B
`define OP_WAI 5'h0C
`define OP_ESE0 5'h0D
`define OP_ESE0_Q 5'h0E
`define OP_DEVICE_EVENT_REG_ZERO_Q 5'h0F
`define OP_ESE1 5'h10
`define OP_ESE1_Q 5'h11
`define OP_DEVICE_EVENT_REG_ONE_Q 5'h12
`define OP_FUNC 5'h13
`define OP_RANGE 5'h14
`define OP_FETCH_Q 5'h15
`define OP_READ_Q 5'h16
`define OP_ADJ_Q 5'h17
`define OP_BACKUP 5'h18
`define OP_INIT 5'h19
`define OP_HEADER 5'h1A

// standard event and status byte bits
`define SE_PON 7
`define SE_CME 5
`define SE_EXE 4
`define SE_DDE 3
`define SE_QYE 2
`define SE_OPC 0
`define SESR_PWRON 8'h80
`define SB_DEVICE_EVENT_SUMMARY_ZERO 0
`define SB_DEVICE_EVENT_SUMMARY_ONE 1
`define SB_MAV 4
`define SB_ESB 5
`define SB_MSS 6

`endif

// ===== hdl/exec_timer.v
// execution time counter: busy for a loaded number of cycles, then one done pulse
`timescale 1ns/1ps
`default_nettype none
module exec_timer #(
   parameter CW = 28
) (
   input wire core_clk,
   input wire rst,
   input wire start,
   input wire abort,
   input wire [CW-1:0] limit,
   output reg busy_q,
   output reg done_q
);
   reg [CW-1:0] cnt_q;

   // abort wins so a cleared command never reports completion
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= {CW{1'b0}};
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (abort) begin
            busy_q <= 1'b0;
            cnt_q <= {CW{1'b0}};
         end else if (start) begin
            busy_q <= 1'b1;
            cnt_q <= limit;
         end else if (busy_q) begin
            if (cnt_q <= {{(CW-1){1'b0}}, 1'b1}) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
            cnt_q <= cnt_q - {{(CW-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // exec_timer
`default_nettype wire

// ===== hdl/serial_framer.v
// serial character sender: start bit, eight data bits lsb first, no parity, one stop bit
`timescale 1ns/1ps
`default_nettype none
`include "status_cmd_defs.vh"
module serial_framer #(
   parameter DIV = `BAUD_DIV
) (
   input wire core_clk,
   input wire rst,
   input wire start,
   input wire [7:0] data,
   output reg busy_q,
   output reg txd_q
);
   reg [13:0] div_q;
   reg [3:0] bit_q;
   reg [9:0] shift_q;
   wire bit_tick;

   // one-cycle enable at the bit rate
   assign bit_tick = (div_q == 14'h0000);

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_q <= 14'h0000;
         bit_q <= 4'h0;
         shift_q <= 10'h3FF;
         busy_q <= 1'b0;
         txd_q <= 1'b1;
      end else if (!busy_q) begin
         txd_q <= 1'b1;
         if (start) begin
            shift_q <= {1'b1, data, 1'b0};
            bit_q <= 4'h0;
            div_q <= 14'h0000;
            busy_q <= 1'b1;
         end
      end else begin
         div_q <= bit_tick ? DIV[13:0] - 14'h0001 : div_q - 14'h0001;
         if (bit_tick) begin
            txd_q <= shift_q[0];
            shift_q <= {1'b1, shift_q[9:1]};
            bit_q <= bit_q + 4'h1;
            // line is released after the tenth bit has had a full bit time
            if (bit_q == `FRAME_BITS) begin
               busy_q <= 1'b0;
               txd_q <= 1'b1;
            end
         end
      end
   end
endmodule // serial_framer
`default_nettype wire

// ===== hdl/status_cmd_handler.v
// remote command handler: status registers, interface messages, init matrix, timing, errors
//
// The placing of the registers and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "status_cmd_defs.vh"
module status_cmd_handler #(
   parameter [27:0] RST_CYC = `T_RST_MS * `CYC_PER_MS,
   parameter [27:0] RANGE_CYC = `T_RANGE_MS * `CYC_PER_MS,
   parameter [27:0] FETCH_CYC = `T_FETCH_MS * `CYC_PER_MS,
   parameter [27:0] ADJ_CYC = `T_ADJ_MS * `CYC_PER_MS,
   parameter [27:0] TST_CYC = `T_TST_MS * `CYC_PER_MS,
   parameter [27:0] BACKUP_CYC = `T_BACKUP_MS * `CYC_PER_MS,
   parameter [27:0] OTHER_CYC = `T_OTHER_MS * `CYC_PER_MS,
   parameter [27:0] READ_CYC = (`T_MEAS_MS + `T_READ_EXTRA_MS) * `CYC_PER_MS,
   parameter BAUD_DIV = `BAUD_DIV
) (
   input wire core_clk,
   input wire rst,
   input wire [3:0] addr,
   input wire [31:0] wdata,
   input wire wr_en,
   input wire rd_en,
   output reg [31:0] rdata_q,
   input wire ren_msg,
   input wire gtl_msg,
   input wire llo_msg,
   input wire dcl_msg,
   input wire sdc_msg,
   input wire get_msg,
   input wire key_local,
   input wire key_reset,
   input wire [7:0] ev0_in,
   input wire [7:0] ev1_in,
   input wire [7:0] meas_data,
   output reg remote_q,
   output reg lockout_q,
   output reg keys_en_q,
   output reg sample_q,
   output reg srq_q,
   output reg gpib_eoi_q,
   output wire txd
);
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_RUN = 2'b10;

   // execution limit per command class
   function [27:0] limit_of;
      input [4:0] op;
      begin
         case (op)
            `OP_RST: limit_of = RST_CYC;
            `OP_FUNC, `OP_RANGE: limit_of = RANGE_CYC;
            `OP_FETCH_Q: limit_of = FETCH_CYC;
            `OP_BACKUP: limit_of = BACKUP_CYC;
            `OP_ADJ_Q: limit_of = ADJ_CYC;
            `OP_TST_Q: limit_of = TST_CYC;
            `OP_READ_Q: limit_of = READ_CYC;
            default: limit_of = OTHER_CYC;
         endcase
      end
   endfunction

   // queries place one response in the output queue
   function is_query;
      input [4:0] op;
      begin
         case (op)
            `OP_ESE_Q, `OP_ESR_Q, `OP_OPC_Q, `OP_SRE_Q, `OP_STB_Q, `OP_TST_Q, `OP_ESE0_Q, `OP_DEVICE_EVENT_REG_ZERO_Q,
            `OP_ESE1_Q, `OP_DEVICE_EVENT_REG_ONE_Q, `OP_FETCH_Q, `OP_READ_Q, `OP_ADJ_Q: is_query = 1'b1;
            default: is_query = 1'b0;
         endcase
      end
   endfunction

   reg [1:0] state_q;
   reg [7:0] sesr_q, seser_q, sre_q, device_event_reg_zero_q, ese0_q, device_event_reg_one_q, ese1_q;
   reg [7:0] oq_q, range_q, pend_data_q, exec_data_q;
   reg [4:0] pend_op_q, exec_op_q, path_q, gpib_addr_q;
   reg pend_q, mav_q, term_q, header_q, eoi_term_q, serial_en_q, local_hold_q;
   reg [7:0] sesr_set, resp_byte;
   reg clr_events, clr_sesr, clr_device_event_reg_zero, clr_device_event_reg_one, load_resp, start_exec, qye_len, send_lf;
   wire [7:0] stb;
   wire timer_busy, timer_done, tx_busy;
   wire cmd_wr, resp_rd, dev_clear, key_rst, tx_start, sample_now;
   wire [4:0] cmd_op;

   // status byte summaries follow the enabled event bits at all times
   assign stb[`SB_DEVICE_EVENT_SUMMARY_ZERO] = |(device_event_reg_zero_q & ese0_q);
   assign stb[`SB_DEVICE_EVENT_SUMMARY_ONE] = |(device_event_reg_one_q & ese1_q);
   assign stb[3:2] = 2'b00;
   assign stb[`SB_MAV] = mav_q;
   assign stb[`SB_ESB] = |(sesr_q & seser_q);
   assign stb[`SB_MSS] = |({stb[5:4], 2'b00, stb[1:0]} & sre_q[5:0]);
   assign stb[7] = 1'b0;

   assign cmd_wr = wr_en && (addr == `OFF_CMD);
   assign resp_rd = rd_en && (addr == `OFF_RESP);
   assign cmd_op = wdata[`CMD_OP_LSB+4:`CMD_OP_LSB];
   assign dev_clear = dcl_msg || sdc_msg;
   assign key_rst = key_reset && keys_en_q;
   assign tx_start = serial_en_q && !tx_busy && (mav_q || term_q) && !dev_clear && !key_rst;
   // trigger and initiate bypass the sequential queue
   assign sample_now = get_msg ||
                       (cmd_wr && !wdata[`CMD_SYNERR_BIT] && !wdata[`CMD_VALERR_BIT] &&
                        (cmd_op == `OP_TRG || cmd_op == `OP_INIT));

   // event decode for this cycle: dispatch, completion and error flags
   always @* begin
      sesr_set = 8'h00;
      clr_events = 1'b0;
      clr_sesr = 1'b0;
      clr_device_event_reg_zero = 1'b0;
      clr_device_event_reg_one = 1'b0;
      load_resp = 1'b0;
      resp_byte = 8'h00;
      start_exec = 1'b0;
      qye_len = 1'b0;
      send_lf = 1'b0;
      if (state_q == ST_IDLE && pend_q && !dev_clear && !key_rst)
         start_exec = 1'b1;
      if (cmd_wr) begin
         if (wdata[`CMD_SYNERR_BIT])
            sesr_set[`SE_CME] = 1'b1;
         else if (wdata[`CMD_VALERR_BIT])
            sesr_set[`SE_EXE] = 1'b1;
         else if (wdata[`CMD_LEN_LSB+6:`CMD_LEN_LSB] > `RESP_MAX_BYTES && is_query(cmd_op))
            qye_len = 1'b1;
         else if (cmd_op != `OP_TRG && cmd_op != `OP_INIT && pend_q && !start_exec)
            sesr_set[`SE_DDE] = 1'b1; // input buffer already holds one command
         if (mav_q && !wdata[`CMD_SYNERR_BIT])
            sesr_set[`SE_QYE] = 1'b1; // unread response met a new command
      end
      if (qye_len)
         sesr_set[`SE_QYE] = 1'b1;
      if (resp_rd) begin
         if (!mav_q && term_q)
            send_lf = 1'b1;
         else if (!mav_q)
            sesr_set[`SE_QYE] = 1'b1; // read of an empty queue
      end
      // completion effects; clear, operation complete and queries land here
      if (timer_done && state_q == ST_RUN) begin
         case (exec_op_q)
            `OP_CLS: clr_events = 1'b1;
            `OP_OPC: sesr_set[`SE_OPC] = 1'b1;
            `OP_ESE_Q: resp_byte = seser_q;
            `OP_SRE_Q: resp_byte = sre_q;
            `OP_ESE0_Q: resp_byte = ese0_q;
            `OP_ESE1_Q: resp_byte = ese1_q;
            `OP_STB_Q: resp_byte = stb;
            `OP_OPC_Q: resp_byte = 8'h01;
            `OP_ESR_Q: begin
               resp_byte = sesr_q;
               clr_sesr = 1'b1;
            end
            `OP_DEVICE_EVENT_REG_ZERO_Q: begin
               resp_byte = device_event_reg_zero_q;
               clr_device_event_reg_zero = 1'b1;
            end
            `OP_DEVICE_EVENT_REG_ONE_Q: begin
               resp_byte = device_event_reg_one_q;
               clr_device_event_reg_one = 1'b1;
            end
            `OP_FETCH_Q, `OP_READ_Q: resp_byte = meas_data;
            default: resp_byte = 8'h00; // self-test and adjustment_query report pass
         endcase
         load_resp = is_query(exec_op_q);
         if (load_resp && mav_q)
            sesr_set[`SE_QYE] = 1'b1; // older response is overwritten and lost
      end
   end

   // command sequencer: one command executes while at most one waits
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         pend_q <= 1'b0;
         pend_op_q <= 5'h00;
         pend_data_q <= 8'h00;
         exec_op_q <= 5'h00;
         exec_data_q <= 8'h00;
         path_q <= 5'h00;
      end else if (dev_clear || key_rst) begin
         state_q <= ST_IDLE;
         pend_q <= 1'b0;
         path_q <= 5'h00;
      end else begin
         if (start_exec) begin
            exec_op_q <= pend_op_q;
            exec_data_q <= pend_data_q;
            path_q <= pend_op_q;
            state_q <= ST_RUN;
         end else if (timer_done) begin
            state_q <= ST_IDLE;
         end else begin
            case (state_q)
               ST_IDLE: state_q <= ST_IDLE;
               ST_RUN: state_q <= ST_RUN;
               default: state_q <= ST_IDLE;
            endcase
         end
         if (cmd_wr && !wdata[`CMD_SYNERR_BIT] && !wdata[`CMD_VALERR_BIT] && !qye_len &&
             cmd_op != `OP_TRG && cmd_op != `OP_INIT && (!pend_q || start_exec)) begin
            pend_q <= 1'b1;
            pend_op_q <= cmd_op;
            pend_data_q <= wdata[`CMD_DATA_LSB+7:`CMD_DATA_LSB];
         end else if (start_exec) begin
            pend_q <= 1'b0;
         end
      end
   end

   // event and enable registers; a new event wins over any clear in the same cycle
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sesr_q <= `SESR_PWRON;
         device_event_reg_zero_q <= 8'h00;
         device_event_reg_one_q <= 8'h00;
         seser_q <= 8'h00;
         sre_q <= 8'h00;
         ese0_q <= 8'h00;
         ese1_q <= 8'h00;
      end else begin
         sesr_q <= ((clr_events || clr_sesr || key_rst) ? 8'h00 : sesr_q) | sesr_set;
         device_event_reg_zero_q <= ((clr_events || clr_device_event_reg_zero || key_rst) ? 8'h00 : device_event_reg_zero_q) | ev0_in;
         device_event_reg_one_q <= ((clr_events || clr_device_event_reg_one || key_rst) ? 8'h00 : device_event_reg_one_q) | {4'h0, ev1_in[3:0]};
         if (key_rst) begin
            seser_q <= 8'h00;
            sre_q <= 8'h00;
            ese0_q <= 8'h00;
            ese1_q <= 8'h00;
         end else if (timer_done && state_q == ST_RUN && !dev_clear) begin
            case (exec_op_q)
               `OP_ESE: seser_q <= exec_data_q;
               `OP_SRE: sre_q <= exec_data_q;
               `OP_ESE0: ese0_q <= exec_data_q;
               `OP_ESE1: ese1_q <= exec_data_q;
               default: sre_q <= sre_q;
            endcase
         end
      end
   end

   // settings; reset command touches only measurement settings and headers
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         range_q <= `RANGE_RST;
         header_q <= 1'b0;
         eoi_term_q <= 1'b1;
         gpib_addr_q <= `GPIB_ADDR_RST;
         serial_en_q <= 1'b0;
      end else if (key_rst) begin
         range_q <= `RANGE_RST;
         header_q <= 1'b0;
         eoi_term_q <= 1'b1;
         gpib_addr_q <= `GPIB_ADDR_RST;
      end else begin
         if (wr_en && addr == `OFF_CTRL) begin
            gpib_addr_q <= wdata[4:0];
            serial_en_q <= wdata[`CTRL_SERIAL_BIT];
         end
         if (timer_done && state_q == ST_RUN && !dev_clear) begin
            case (exec_op_q)
               `OP_RST: begin
                  range_q <= `RANGE_RST;
                  header_q <= 1'b0;
               end
               `OP_FUNC, `OP_RANGE: range_q <= exec_data_q;
               `OP_HEADER: header_q <= exec_data_q[0];
               default: header_q <= header_q;
            endcase
         end
      end
   end

   // output queue of one response byte and its pending terminator
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         oq_q <= 8'h00;
         mav_q <= 1'b0;
         term_q <= 1'b0;
      end else if (dev_clear || key_rst || qye_len) begin
         mav_q <= 1'b0;
         term_q <= 1'b0;
      end else if (load_resp) begin
         oq_q <= resp_byte;
         mav_q <= 1'b1;
         term_q <= 1'b0;
      end else if ((resp_rd || tx_start) && mav_q) begin
         mav_q <= 1'b0;
         term_q <= 1'b1;
      end else if (send_lf || (tx_start && term_q)) begin
         term_q <= 1'b0;
      end
   end

   // remote and lockout state, outputs and bus read data
   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         remote_q <= 1'b0;
         lockout_q <= 1'b0;
         local_hold_q <= 1'b0;
         keys_en_q <= 1'b1;
         sample_q <= 1'b0;
         srq_q <= 1'b0;
         gpib_eoi_q <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         if (!ren_msg || gtl_msg || (key_local && keys_en_q))
            remote_q <= 1'b0;
         else if (!local_hold_q)
            remote_q <= 1'b1;
         if (!ren_msg)
            local_hold_q <= 1'b0;
         else if (gtl_msg || (key_local && keys_en_q))
            local_hold_q <= 1'b1; // stays local until remote enable drops
         if (!ren_msg)
            lockout_q <= 1'b0;
         else if (llo_msg)
            lockout_q <= 1'b1;
         keys_en_q <= !(ren_msg && (lockout_q || llo_msg)); // tracks next lockout, no stale cycle
         sample_q <= sample_now;
         srq_q <= stb[`SB_MSS];
         gpib_eoi_q <= send_lf && eoi_term_q;
         rdata_q <= 32'h00000000;
         if (rd_en) begin
            case (addr)
               `OFF_RESP: begin
                  if (mav_q)
                     rdata_q <= {23'h000000, 1'b1, oq_q};
                  else if (term_q)
                     rdata_q <= {22'h000000, eoi_term_q, 1'b1, `LF_CHAR};
               end
               `OFF_STAT: rdata_q <= {6'h00, range_q, path_q, gpib_addr_q, header_q, eoi_term_q,
                                      lockout_q, remote_q, mav_q, pend_q, timer_busy, state_q[1]};
               `OFF_CTRL: rdata_q <= {23'h000000, serial_en_q, 3'h0, gpib_addr_q};
               default: rdata_q <= 32'h00000000;
            endcase
         end
      end
   end

   exec_timer #(.CW(28)) timer_u (
      .core_clk(core_clk),
      .rst(rst),
      .start(start_exec),
      .abort(dev_clear || key_rst),
      .limit(limit_of(pend_op_q)),
      .busy_q(timer_busy),
      .done_q(timer_done)
   );

   serial_framer #(.DIV(BAUD_DIV)) tx_u (
      .core_clk(core_clk),
      .rst(rst),
      .start(tx_start),
      .data(mav_q ? oq_q : `LF_CHAR),
      .busy_q(tx_busy),
      .txd_q(txd)
   );
endmodule // status_cmd_handler
`default_nettype wire

// ===== verif/status_cmd_monitor.sv
// port checker for the remote status command handler
`timescale 1ns/1ps
`default_nettype none
module status_cmd_monitor (
   input wire core_clk,
   input wire rst,
   input wire [3:0] addr,
   input wire wr_en,
   input wire rd_en,
   input wire [31:0] rdata_q,
   input wire ren_msg,
   input wire gtl_msg,
   input wire llo_msg,
   input wire dcl_msg,
   input wire get_msg,
   input wire remote_q,
   input wire lockout_q,
   input wire keys_en_q,
   input wire sample_q,
   input wire gpib_eoi_q,
   input wire txd
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   // interface messages act in the cycle after they are taken
   a_get_sample: assert property (get_msg |=> sample_q) else $error("no sample");
   a_sample_cause: assert property (sample_q |-> $past(get_msg) || $past(wr_en) || $past(wr_en, 2))
      else $error("stray sample");
   a_gtl_local: assert property (gtl_msg |=> !remote_q) else $error("still remote");
   a_gtl_hold: assert property (gtl_msg ##1 ren_msg |=> !remote_q) else $error("remote regained");
   a_llo_locks: assert property (llo_msg && ren_msg |=> lockout_q && !keys_en_q) else $error("no lockout");
   a_lock_keys: assert property (lockout_q |-> !keys_en_q) else $error("keys live");
   a_ren_release: assert property (!ren_msg |=> !remote_q && !lockout_q && keys_en_q)
      else $error("remote kept");
   // a flushed queue answers a prompt response read with nothing
   a_dcl_flush: assert property (dcl_msg ##[1:2] (rd_en && addr == 4'h4) |=> rdata_q == 32'h0)
      else $error("response kept");
   a_eoi_lf: assert property (gpib_eoi_q |-> $past(rd_en) && rdata_q[9:0] == 10'h30A)
      else $error("eoi without lf");
   // the bench runs the framer with a divider of 8
   a_start_bit: assert property ($fell(txd) |-> (!txd) [*8]) else $error("short start");
   c_trigger: cover property (get_msg ##1 sample_q);
   c_eoi: cover property (gpib_eoi_q);
   c_frame: cover property ($fell(txd));
endmodule // status_cmd_monitor

bind status_cmd_handler status_cmd_monitor i_mon (.*);
`default_nettype wire

// ===== verif/serial_rx_model.sv
// controller side serial receiver
`timescale 1ns/1ps
`default_nettype none
module serial_rx_model #(
   parameter int DIV = 8
) (
   input wire logic core_clk,
   input wire logic txd,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic frame_err
);
   logic [9:0] fr;
   // sample mid-bit so edge jitter of the sender cannot mislead us
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      frame_err = 1'b0;
      forever begin
         @(negedge txd);
         repeat (DIV / 2) @(posedge core_clk);
         for (int i = 0; i < 10; i++) begin
            fr[i] = txd;
            if (i < 9) repeat (DIV) @(posedge core_clk);
         end
         rx_byte = fr[8:1];
         frame_err = fr[0] | ~fr[9];
         rx_valid = 1'b1;
         #1 rx_valid = 1'b0;
      end
   end
endmodule // serial_rx_model
`default_nettype wire

// ===== verif/status_cmd_handler_tb.sv
// self-checking bench for the remote status command handler
`timescale 1ns/1ps
`default_nettype none
`include "status_cmd_defs.vh"
module status_cmd_handler_tb;
   localparam [27:0] LIM = 28'h028; // all execution limits shortened
   logic core_clk = 0, rst = 1, wr_en = 0, rd_en = 0, rd_d = 0, ren_msg = 0, key_local = 0;
   logic [5:0] msg = 0; // key reset, trigger, sel clear, clear, lockout, local
   wire gtl_msg, llo_msg, dcl_msg, sdc_msg, get_msg, key_reset;
   logic [3:0] addr = 0;
   logic [7:0] ev0_in = 0, ev1_in = 0, meas_data = 0, v;
   logic [31:0] wdata = 0;
   logic [67:0] e, rq[$]; // address, expected, mask
   logic [7:0] sq[$];
   wire [31:0] rdata_q;
   wire [7:0] rx_byte;
   wire remote_q, lockout_q, keys_en_q, sample_q, srq_q, gpib_eoi_q, txd, rx_valid, frame_err;
   logic [4:0] so[4] = '{`OP_ESE, `OP_SRE, `OP_ESE0, `OP_ESE1};
   logic [4:0] qo[4] = '{`OP_ESE_Q, `OP_SRE_Q, `OP_ESE0_Q, `OP_ESE1_Q};
   int errors = 0, tests_run = 0, samples = 0, seed = 32'hE737;
   assign {gtl_msg, llo_msg, dcl_msg, sdc_msg, get_msg, key_reset} = msg;
   always #5 core_clk = ~core_clk;
   status_cmd_handler #(.RST_CYC(LIM), .RANGE_CYC(LIM), .FETCH_CYC(LIM), .ADJ_CYC(LIM), .TST_CYC(LIM),
      .BACKUP_CYC(LIM), .OTHER_CYC(LIM), .READ_CYC(LIM), .BAUD_DIV(8)) i_dut (.*);
   serial_rx_model #(.DIV(8)) i_ctl (.core_clk, .txd, .rx_valid, .rx_byte, .frame_err);
   task automatic chk(string n, logic [31:0] x, logic [31:0] s);
      tests_run++;
      if (s !== x) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", n, x, s);
      end
   endtask
   // read data stands only in the cycle after the strobe
   always @(posedge core_clk) rd_d <= rd_en;
   always @(negedge core_clk) if (rd_d) begin
      e = rq.pop_front();
      chk($sformatf("read %h", e[67:64]), e[63:32] & e[31:0], rdata_q & e[31:0]);
   end
   always @(posedge rx_valid) chk("serial", {24'h0, sq.pop_front()}, {23'h0, frame_err, rx_byte});
   always @(posedge core_clk) if (sample_q === 1'b1) samples++;
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge core_clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1;
      @(posedge core_clk);
      wr_en <= 0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] x, logic [31:0] m = 32'hFFFFFFFF);
      rq.push_back({a, x, m});
      @(posedge core_clk);
      addr <= a;
      rd_en <= 1;
      @(posedge core_clk);
      rd_en <= 0;
   endtask
   task automatic pulse(int i);
      @(posedge core_clk);
      msg[i] <= 1;
      @(posedge core_clk);
      msg[i] <= 0;
   endtask
   task automatic cmd(logic [4:0] op, logic [7:0] d = 0, logic [1:0] f = 0, logic [6:0] n = 7'h40);
      wr(4'h0, {6'h00, f, 1'b0, n, d, 3'h0, op});
   endtask
   // fixed wait: each command must be done within its limit
   task automatic run(int k);
      repeat (k * (LIM + 6)) @(posedge core_clk);
   endtask
   task automatic st(logic [4:0] op, logic [7:0] d);
      cmd(op, d);
      run(1);
   endtask
   task automatic q(logic [4:0] op, logic [7:0] x, logic [7:0] m = 8'hFF);
      cmd(op);
      run(2);
      rd(4'h4, {24'h1, x}, {24'h1, m});
      rd(4'h4, 32'h0000030A);
   endtask
   task automatic ser(logic [4:0] op, logic [7:0] x);
      sq.push_back(x);
      sq.push_back(8'h0A);
      cmd(op);
      repeat (LIM + 200) @(posedge core_clk);
   endtask
   task automatic complete_run;
      $display("checks %0d mismatches %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 0;
      q(`OP_ESR_Q, 8'h80);
      q(`OP_ESR_Q, 8'h00);
      foreach (qo[i]) q(qo[i], 8'h00);
      rd(4'h8, 32'h00000140, 32'h00001FF0);
      $display("reset values done");
      foreach (so[i]) begin
         v = 8'($random(seed)) & 8'hBF;
         cmd(so[i], v);
         q(qo[i], v);
      end
      $display("enables done");
      st(`OP_ESE, 8'h34);
      st(`OP_ESE0, 8'hFF);
      st(`OP_ESE1, 8'h0F);
      st(`OP_SRE, 8'h20);
      for (int i = 0; i < 3; i++) begin
         cmd(`OP_ESR_Q, 0, i == 2 ? 2'h0 : 2'(i + 1), i == 2 ? 7'h41 : 7'h40);
         q(`OP_STB_Q, 8'h20, 8'h20);
         chk("srq", 32'h1, srq_q);
         q(`OP_ESR_Q, 8'h20 >> (i == 2 ? 3 : i));
      end
      @(posedge core_clk);
      ev0_in <= 8'h41;
      ev1_in <= 8'h08;
      @(posedge core_clk);
      ev0_in <= 8'h00;
      ev1_in <= 8'h00;
      q(`OP_STB_Q, 8'h03, 8'h23);
      q(`OP_DEVICE_EVENT_REG_ZERO_Q, 8'h41);
      q(`OP_DEVICE_EVENT_REG_ONE_Q, 8'h08);
      st(`OP_CLS, 0);
      q(`OP_STB_Q, 8'h00, 8'h23);
      q(`OP_ESE0_Q, 8'hFF);
      $display("status done");
      st(`OP_HEADER, 8'h01);
      st(`OP_RANGE, 8'h5A);
      rd(4'h8, 32'h01680080, 32'h03FC0080);
      st(`OP_RST, 0);
      rd(4'h8, 32'h00000000, 32'h03FC0080);
      q(`OP_ESE0_Q, 8'hFF);
      v = 8'($random(seed));
      meas_data <= v;
      q(`OP_FETCH_Q, v);
      q(`OP_READ_Q, v);
      q(`OP_ADJ_Q, 8'h00);
      q(`OP_TST_Q, 8'h00);
      for (int i = 2; i < 4; i++) begin
         cmd(`OP_ESE0_Q);
         run(1);
         pulse(i);
         rd(4'h4, 32'h0);
      end
      q(`OP_ESE0_Q, 8'hFF);
      q(`OP_ESR_Q, 8'h04);
      $display("clears done");
      ren_msg <= 1;
      pulse(4);
      @(negedge core_clk);
      chk("lockout", 32'h2, {lockout_q, keys_en_q});
      pulse(0);
      q(`OP_ESE0_Q, 8'hFF);
      @(posedge core_clk);
      key_local <= 1;
      @(posedge core_clk);
      key_local <= 0;
      @(negedge core_clk);
      chk("remote", 32'h1, remote_q);
      pulse(5);
      repeat (3) @(negedge core_clk);
      chk("gtl", 32'h0, remote_q);
      @(posedge core_clk);
      ren_msg <= 0;
      pulse(5);
      @(negedge core_clk);
      chk("local", 32'h1, {remote_q, lockout_q, keys_en_q});
      cmd(`OP_TRG);
      cmd(`OP_INIT);
      pulse(1);
      run(1);
      chk("samples", 32'h3, samples);
      $display("messages done");
      wr(4'hC, 32'h0000011F);
      v = 8'($random(seed));
      st(`OP_ESE0, v);
      ser(`OP_ESE0_Q, v);
      pulse(0);
      rd(4'hC, 32'h00000101, 32'h0000011F);
      ser(`OP_ESE0_Q, 8'h00);
      ser(`OP_ESR_Q, 8'h00);
      $display("key reset done");
      repeat (4) @(posedge core_clk);
      complete_run();
   end
   // about twelve times the expected run length
   initial begin
      #500000;
      errors++;
      complete_run();
   end
endmodule // status_cmd_handler_tb
`default_nettype wire
